// ---- rtl/net_frame_master.sv ----
`timescale 1ns/1ps
`include "net_frame_map.svh"

module net_frame_master
    import net_frame_pkg::*;
#(
    parameter variant_t VARIANT = VAR_FIRST
) (
    input  wire logic         mclk,
    input  wire logic         arst_n,
    net_frame_if.mst          link,
    input  wire logic         frame_start,
    input  wire logic [127:0] io_in_words,
    input  wire logic         reg_cmd_valid,
    input  wire logic [15:0]  reg_axis,
    input  wire logic [13:0]  reg_code,
    input  wire logic [31:0]  reg_wdata,
    output logic              busy_ff,
    output logic              frame_done_ff,
    output logic              code_err_ff,
    output logic [127:0]      io_out_words_ff,
    output logic              reg_idle_ff,
    output logic              reg_done_ff,
    output logic              reg_status_ff,
    output logic [31:0]       reg_rdata_ff
);
    localparam int BASE = (VARIANT == VAR_FIRST) ? `NF_BASE_FIRST : `NF_BASE_SECOND;
    localparam logic [7:0] CODE = (VARIANT == VAR_FIRST) ? `NF_CODE_FIRST : `NF_CODE_SECOND;
    localparam logic [4:0] SLOT = 5'(((VARIANT == VAR_FIRST) ? `NF_SLOT_FIRST : `NF_SLOT_SECOND) - BASE);
    localparam logic [4:0] RADR = 5'(((VARIANT == VAR_FIRST) ? `NF_RADR_FIRST : `NF_RADR_SECOND) - BASE);
    localparam logic [4:0] CCOD = 5'(((VARIANT == VAR_FIRST) ? `NF_CCODE_FIRST : `NF_CCODE_SECOND) - BASE);
    localparam logic [4:0] DATA = 5'(((VARIANT == VAR_FIRST) ? `NF_DATA_FIRST : `NF_DATA_SECOND) - BASE);
    localparam int DLEN = (VARIANT == VAR_FIRST) ? `NF_DLEN_FIRST : `NF_DLEN_SECOND;

    mst_state_t st_ff;
    reg_state_t rs_ff;
    logic [4:0]  cnt_ff;
    logic        cmd_valid_ff, cmd_sof_ff;
    logic [7:0]  cmd_data_ff, nxt_cmd_data;
    logic [7:0]  rx_ff [`NF_FRAME_BYTES];
    logic [127:0] io_snap_ff;
    logic [15:0] axis_ff;
    logic [13:0] code_ff;
    logic [31:0] wdata_ff;
    logic [15:0] rsp_cword;
    logic [31:0] rsp_rdata;
    logic [4:0]  rx_idx;

    assign link.cmd_valid = cmd_valid_ff;
    assign link.cmd_sof   = cmd_sof_ff;
    assign link.cmd_data  = cmd_data_ff;

    // Command byte for the slot now being sent; unused bytes go out as zero
    always_comb begin
        nxt_cmd_data = 8'h00;
        if (cnt_ff == 5'd0) begin
            nxt_cmd_data = CODE;
        end else if (cnt_ff >= SLOT && cnt_ff < SLOT + 5'd16) begin
            nxt_cmd_data = io_snap_ff[8*(cnt_ff - SLOT) +: 8];
        end else if (cnt_ff == RADR || cnt_ff == RADR + 5'd1) begin
            nxt_cmd_data = axis_ff[8*(cnt_ff - RADR) +: 8];
        end else if (cnt_ff == CCOD) begin
            nxt_cmd_data = code_ff[7:0];
        end else if (cnt_ff == CCOD + 5'd1) begin
            // Trigger held high only while a transaction is armed
            nxt_cmd_data = {1'b0, rs_ff == REG_EXEC_REQUEST, code_ff[13:8]};
        end else if (cnt_ff >= DATA && cnt_ff < DATA + 5'(DLEN)) begin
            nxt_cmd_data = wdata_ff[8*(cnt_ff - DATA) +: 8];
        end
    end

    assign rx_idx    = link.rsp_sof ? 5'd0 : cnt_ff;
    assign rsp_cword = {rx_ff[CCOD + 5'd1], rx_ff[CCOD]};
    always_comb begin
        rsp_rdata = 32'h0;
        for (int k = 0; k < DLEN; k++) begin
            rsp_rdata[8*k +: 8] = rx_ff[DATA + 5'(k)];
        end
    end

    // ======================================================================
    // Frame sequencing
    // ======================================================================
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            st_ff         <= MST_IDLE;
            cnt_ff        <= 5'd0;
            cmd_valid_ff  <= 1'b0;
            cmd_sof_ff    <= 1'b0;
            cmd_data_ff   <= 8'h00;
            busy_ff       <= 1'b0;
            frame_done_ff <= 1'b0;
            code_err_ff   <= 1'b0;
            io_snap_ff    <= '0;
        end else begin
            frame_done_ff <= 1'b0;
            cmd_valid_ff  <= 1'b0;
            cmd_sof_ff    <= 1'b0;
            case (st_ff)
                MST_IDLE: begin
                    if (frame_start) begin
                        io_snap_ff <= io_in_words;
                        busy_ff    <= 1'b1;
                        cnt_ff     <= 5'd0;
                        st_ff      <= MST_TX;
                    end
                end
                MST_TX: begin
                    cmd_valid_ff <= 1'b1;
                    cmd_sof_ff   <= (cnt_ff == 5'd0);
                    cmd_data_ff  <= nxt_cmd_data;
                    cnt_ff       <= cnt_ff + 5'd1;
                    if (cnt_ff == 5'(`NF_FRAME_BYTES - 1)) begin
                        st_ff <= MST_RX;
                    end
                end
                MST_RX: begin
                    if (link.rsp_valid) begin
                        cnt_ff <= rx_idx + 5'd1;
                        if (rx_idx == 5'(`NF_FRAME_BYTES - 1)) begin
                            st_ff <= MST_EVAL;
                        end
                    end
                end
                MST_EVAL: begin
                    code_err_ff   <= (rx_ff[0] != CODE);
                    frame_done_ff <= 1'b1;
                    busy_ff       <= 1'b0;
                    st_ff         <= MST_IDLE;
                end
                default: st_ff <= MST_IDLE;
            endcase
        end
    end

    // Response capture; bytes are plain storage so no reset is needed
    always_ff @(posedge mclk) begin
        if (st_ff == MST_RX && link.rsp_valid) begin
            rx_ff[rx_idx] <= link.rsp_data;
        end
    end

    // Output words per axis
    for (genvar a = 0; a < `NF_AXES; a++) begin : g_io
        always_ff @(posedge mclk or negedge arst_n) begin
            if (!arst_n) begin
                io_out_words_ff[16*a +: 16] <= 16'h0000;
            end else if (st_ff == MST_EVAL && rx_ff[0] == CODE) begin
                io_out_words_ff[16*a +: 16] <= {rx_ff[SLOT + 5'(2*a + 1)], rx_ff[SLOT + 5'(2*a)]};
            end
        end
    end

    // ======================================================================
    // Register transaction handshake
    // ======================================================================
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rs_ff         <= REG_IDLE;
            reg_idle_ff   <= 1'b1;
            reg_done_ff   <= 1'b0;
            reg_status_ff <= 1'b0;
            reg_rdata_ff  <= 32'h0;
            axis_ff       <= 16'h0000;
            code_ff       <= 14'h0000;
            wdata_ff      <= 32'h0;
        end else begin
            reg_done_ff <= 1'b0;
            case (rs_ff)
                REG_IDLE: begin
                    if (reg_cmd_valid) begin
                        axis_ff     <= reg_axis;
                        code_ff     <= reg_code;
                        wdata_ff    <= reg_wdata;
                        reg_idle_ff <= 1'b0;
                        rs_ff       <= REG_EXEC_REQUEST;
                    end
                end
                REG_EXEC_REQUEST: begin
                    if (st_ff == MST_EVAL && rx_ff[0] == CODE && rsp_cword[`NF_EXEC_REQUEST_BIT]) begin
                        reg_status_ff <= rsp_cword[`NF_STATUS_BIT];
                        reg_rdata_ff  <= rsp_rdata;
                        reg_done_ff   <= 1'b1;
                        rs_ff         <= REG_CLEAR;
                    end
                end
                REG_CLEAR: begin
                    // Next command waits until the done bit has dropped
                    if (st_ff == MST_EVAL && rx_ff[0] == CODE && !rsp_cword[`NF_EXEC_REQUEST_BIT]) begin
                        reg_idle_ff <= 1'b1;
                        rs_ff       <= REG_IDLE;
                    end
                end
                default: rs_ff <= REG_IDLE;
            endcase
        end
    end

endmodule : net_frame_master

// ---- rtl/net_frame_map.svh ----
`ifndef NET_FRAME_MAP_SVH
`define NET_FRAME_MAP_SVH

// ==========================================================================
// Frame geometry, factory layout: 16-bit I/O slots, 32-byte frames
// ==========================================================================
`define NF_FRAME_BYTES  32
`define NF_AXES         8
`define NF_IO_BITS      16
`define NF_DATA_BYTES   4

// ==========================================================================
// Exchange command codes, byte 0 of both frames
// ==========================================================================
`define NF_CODE_FIRST   8'h50
`define NF_CODE_SECOND  8'h20

// ==========================================================================
// Printed byte numbers and the printed number of the first byte
// ==========================================================================
`define NF_BASE_FIRST   1
`define NF_BASE_SECOND  0
`define NF_SLOT_FIRST   7
`define NF_SLOT_SECOND  6
`define NF_RADR_FIRST   23
`define NF_RADR_SECOND  22
`define NF_CCODE_FIRST  25
`define NF_CCODE_SECOND 24
`define NF_DATA_FIRST   27
`define NF_DATA_SECOND  27
`define NF_DLEN_FIRST   4
`define NF_DLEN_SECOND  3

// ==========================================================================
// Fields of the 16-bit command code word
// ==========================================================================
`define NF_CODE_W       14
`define NF_EXEC_REQUEST_BIT     14
`define NF_STATUS_BIT   15

`endif

// ---- rtl/net_frame_pkg.sv ----
`include "net_frame_map.svh"

package net_frame_pkg;

    // ======================================================================
    // Types
    // ======================================================================
    typedef enum logic {
        VAR_FIRST  = 1'b0,
        VAR_SECOND = 1'b1
    } variant_t;

    typedef enum logic [1:0] {
        DEV_RX   = 2'b00,
        DEV_EVAL = 2'b01,
        DEV_TX   = 2'b10
    } dev_state_t;

    typedef enum logic [1:0] {
        MST_IDLE = 2'b00,
        MST_TX   = 2'b01,
        MST_RX   = 2'b10,
        MST_EVAL = 2'b11
    } mst_state_t;

    typedef enum logic [1:0] {
        REG_IDLE  = 2'b00,
        REG_EXEC_REQUEST  = 2'b01,
        REG_CLEAR = 2'b10
    } reg_state_t;

endpackage : net_frame_pkg

// ---- rtl/net_frame_if.sv ----
`timescale 1ns/1ps

// ==========================================================================
// Byte-wide frame link between master and converter end
// ==========================================================================
interface net_frame_if;
    logic       cmd_valid;
    logic       cmd_sof;
    logic [7:0] cmd_data;
    logic       rsp_valid;
    logic       rsp_sof;
    logic [7:0] rsp_data;

    modport dev (input cmd_valid, input cmd_sof, input cmd_data,
                 output rsp_valid, output rsp_sof, output rsp_data);
    modport mst (output cmd_valid, output cmd_sof, output cmd_data,
                 input rsp_valid, input rsp_sof, input rsp_data);
endinterface : net_frame_if

// ---- rtl/net_frame_device.sv ----
`timescale 1ns/1ps
`include "net_frame_map.svh"


module net_frame_device
    import net_frame_pkg::*;
#(
    parameter variant_t VARIANT = VAR_FIRST
) (
    input  wire logic         mclk,
    input  wire logic         arst_n,
    net_frame_if.dev          link,
    output logic [127:0]      io_in_words_ff,
    output logic              io_update_ff,
    input  wire logic [127:0] io_out_words,
    output logic              reg_req_ff,
    output logic [15:0]       reg_axis_ff,
    output logic [13:0]       reg_code_ff,
    output logic [31:0]       reg_wdata_ff,
    input  wire logic         reg_ack,
    input  wire logic         reg_status,
    input  wire logic [31:0]  reg_rdata,
    output logic              reg_busy_ff,
    output logic              bad_frame_ff
);
    // ======================================================================
    // Variant geometry, as frame indices from the first byte
    // ======================================================================
    localparam int BASE = (VARIANT == VAR_FIRST) ? `NF_BASE_FIRST : `NF_BASE_SECOND;
    localparam logic [7:0] CODE = (VARIANT == VAR_FIRST) ? `NF_CODE_FIRST : `NF_CODE_SECOND;
    localparam logic [4:0] SLOT = 5'(((VARIANT == VAR_FIRST) ? `NF_SLOT_FIRST : `NF_SLOT_SECOND) - BASE);
    localparam logic [4:0] RADR = 5'(((VARIANT == VAR_FIRST) ? `NF_RADR_FIRST : `NF_RADR_SECOND) - BASE);
    localparam logic [4:0] CCOD = 5'(((VARIANT == VAR_FIRST) ? `NF_CCODE_FIRST : `NF_CCODE_SECOND) - BASE);
    localparam logic [4:0] DATA = 5'(((VARIANT == VAR_FIRST) ? `NF_DATA_FIRST : `NF_DATA_SECOND) - BASE);
    localparam int DLEN = (VARIANT == VAR_FIRST) ? `NF_DLEN_FIRST : `NF_DLEN_SECOND;

    // Layout only holds for the factory frame size and slot width
    if (`NF_FRAME_BYTES != 32 || `NF_IO_BITS != 16 || DLEN > `NF_DATA_BYTES) begin : g_bad_layout
        $error("net_frame_device: unsupported frame layout");
    end

    dev_state_t  st_ff;
    logic [4:0]  cnt_ff;
    logic [7:0]  rx_ff [`NF_FRAME_BYTES];
    logic [4:0]  rx_idx;
    logic        exec_request_prev_ff;
    logic        done_ff;
    logic        status_ff;
    logic [31:0] rdata_ff;
    logic        rsp_valid_ff, rsp_sof_ff;
    logic [7:0]  rsp_data_ff, nxt_rsp_data;
    logic [15:0] cmd_cword;
    logic [15:0] cmd_axis;
    logic [31:0] cmd_wdata;
    logic        frame_ok;
    logic        exec_request_rise;

    assign link.rsp_valid = rsp_valid_ff;
    assign link.rsp_sof   = rsp_sof_ff;
    assign link.rsp_data  = rsp_data_ff;

    // ======================================================================
    // Command frame decode
    // ======================================================================
    assign rx_idx    = link.cmd_sof ? 5'd0 : cnt_ff;
    assign cmd_cword = {rx_ff[CCOD + 5'd1], rx_ff[CCOD]};
    assign cmd_axis  = {rx_ff[RADR + 5'd1], rx_ff[RADR]};
    assign frame_ok  = (rx_ff[0] == CODE);
    // Level alone never starts work; only a fresh 0-to-1 step does
    assign exec_request_rise = frame_ok && cmd_cword[`NF_EXEC_REQUEST_BIT] && !exec_request_prev_ff;

    // Little endian write data; bytes past the field length read as zero
    always_comb begin
        cmd_wdata = 32'h0;
        for (int k = 0; k < DLEN; k++) begin
            cmd_wdata[8*k +: 8] = rx_ff[DATA + 5'(k)];
        end
    end

    // Frame sequencing: collect 32 bytes, evaluate, answer 32 bytes when the code is right
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            st_ff        <= DEV_RX;
            cnt_ff       <= 5'd0;
            io_update_ff <= 1'b0;
            bad_frame_ff <= 1'b0;
            rsp_valid_ff <= 1'b0;
            rsp_sof_ff   <= 1'b0;
            rsp_data_ff  <= 8'h00;
        end else begin
            io_update_ff <= 1'b0;
            rsp_valid_ff <= 1'b0;
            rsp_sof_ff   <= 1'b0;
            case (st_ff)
                DEV_RX: begin
                    if (link.cmd_valid) begin
                        cnt_ff <= rx_idx + 5'd1;
                        if (rx_idx == 5'(`NF_FRAME_BYTES - 1)) begin
                            st_ff <= DEV_EVAL;
                        end
                    end
                end
                DEV_EVAL: begin
                    // Foreign codes get no answer so the master cannot mistake them
                    bad_frame_ff <= !frame_ok;
                    io_update_ff <= frame_ok;
                    cnt_ff       <= 5'd0;
                    st_ff        <= frame_ok ? DEV_TX : DEV_RX;
                end
                DEV_TX: begin
                    rsp_valid_ff <= 1'b1;
                    rsp_sof_ff   <= (cnt_ff == 5'd0);
                    rsp_data_ff  <= nxt_rsp_data;
                    cnt_ff       <= cnt_ff + 5'd1;
                    if (cnt_ff == 5'(`NF_FRAME_BYTES - 1)) begin
                        st_ff <= DEV_RX;
                    end
                end
                default: st_ff <= DEV_RX;
            endcase
        end
    end

    // Command bytes; storage only, reserved bytes are kept but never read
    always_ff @(posedge mclk) begin
        if (st_ff == DEV_RX && link.cmd_valid) begin
            rx_ff[rx_idx] <= link.cmd_data;
        end
    end

    // Input words per axis, taken only from frames with the right code
    for (genvar a = 0; a < `NF_AXES; a++) begin : g_io
        always_ff @(posedge mclk or negedge arst_n) begin
            if (!arst_n) begin
                io_in_words_ff[16*a +: 16] <= 16'h0000;
            end else if (st_ff == DEV_EVAL && frame_ok) begin
                io_in_words_ff[16*a +: 16] <= {rx_ff[SLOT + 5'(2*a + 1)], rx_ff[SLOT + 5'(2*a)]};
            end
        end
    end

    // ======================================================================
    // Register transaction
    // ======================================================================
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            exec_request_prev_ff <= 1'b0;
            reg_req_ff   <= 1'b0;
            reg_busy_ff  <= 1'b0;
            reg_axis_ff  <= 16'h0000;
            reg_code_ff  <= 14'h0000;
            reg_wdata_ff <= 32'h0;
        end else begin
            reg_req_ff <= 1'b0;
            if (st_ff == DEV_EVAL && frame_ok) begin
                exec_request_prev_ff <= cmd_cword[`NF_EXEC_REQUEST_BIT];
                if (exec_request_rise) begin
                    reg_req_ff   <= 1'b1;
                    reg_busy_ff  <= 1'b1;
                    reg_axis_ff  <= cmd_axis;
                    reg_code_ff  <= cmd_cword[`NF_CODE_W-1:0];
                    reg_wdata_ff <= cmd_wdata;
                end
            end
            if (reg_ack) begin
                reg_busy_ff <= 1'b0;
            end
        end
    end

    // Completion flag: an ack beats a same-cycle clear by a dropped request
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            done_ff   <= 1'b0;
            status_ff <= 1'b0;
            rdata_ff  <= 32'h0;
        end else if (reg_ack && reg_busy_ff) begin
            done_ff   <= 1'b1;
            status_ff <= reg_status;
            rdata_ff  <= reg_rdata;
        end else if (st_ff == DEV_EVAL && frame_ok && !cmd_cword[`NF_EXEC_REQUEST_BIT]) begin
            done_ff <= 1'b0;
        end
    end

    // ======================================================================
    // Response byte for the position now being sent
    // ======================================================================
    always_comb begin
        nxt_rsp_data = 8'h00;
        if (cnt_ff == 5'd0) begin
            nxt_rsp_data = CODE;
        end else if (cnt_ff >= SLOT && cnt_ff < SLOT + 5'd16) begin
            nxt_rsp_data = io_out_words[8*(cnt_ff - SLOT) +: 8];
        end else if (cnt_ff == RADR || cnt_ff == RADR + 5'd1) begin
            nxt_rsp_data = rx_ff[cnt_ff];
        end else if (cnt_ff == CCOD) begin
            nxt_rsp_data = rx_ff[CCOD];
        end else if (cnt_ff == CCOD + 5'd1) begin
            // Result and done ride above the echoed upper code bits
            nxt_rsp_data = {status_ff & done_ff, done_ff, rx_ff[CCOD + 5'd1][5:0]};
        end else if (cnt_ff >= DATA && cnt_ff < DATA + 5'(DLEN)) begin
            nxt_rsp_data = rdata_ff[8*(cnt_ff - DATA) +: 8];
        end
    end

endmodule : net_frame_device

// ---- tb/net_frame_properties.sv ----
`timescale 1ns/1ps

// ============================================================
// Link checks between the two frame ends
// ============================================================
module net_frame_properties #(
    parameter logic [7:0] CODE = 8'h50
) (
    input wire logic       mclk,
    input wire logic       arst_n,
    input wire logic       cmd_valid,
    input wire logic       cmd_sof,
    input wire logic [7:0] cmd_data,
    input wire logic       rsp_valid,
    input wire logic       rsp_sof,
    input wire logic [7:0] rsp_data
);
    logic [5:0] cidx_ff;
    logic [5:0] ridx_ff;

    // Byte counters, restarted by sof so a lost byte shows up as a bad length
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cidx_ff <= 6'h00;
            ridx_ff <= 6'h00;
        end else begin
            if (cmd_valid) cidx_ff <= cmd_sof ? 6'h01 : cidx_ff + 6'h01;
            if (rsp_valid) ridx_ff <= rsp_sof ? 6'h01 : ridx_ff + 6'h01;
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);

    property p_cmd_code; cmd_valid && cmd_sof |-> cmd_data == CODE; endproperty
    a_cmd_code: assert property (p_cmd_code) else $error("bad command code");
    property p_rsp_code; rsp_valid && rsp_sof |-> rsp_data == CODE; endproperty
    a_rsp_code: assert property (p_rsp_code) else $error("bad response code");
    property p_cmd_len; $fell(cmd_valid) |-> cidx_ff == 6'h20; endproperty
    a_cmd_len: assert property (p_cmd_len) else $error("command not 32 bytes");
    property p_rsp_len; $fell(rsp_valid) |-> ridx_ff == 6'h20; endproperty
    a_rsp_len: assert property (p_rsp_len) else $error("response not 32 bytes");
    property p_turn; cmd_valid && !cmd_sof && cidx_ff == 6'h1F |-> ##3 (rsp_valid && rsp_sof); endproperty
    a_turn: assert property (p_turn) else $error("response late or missing");
    property p_cmd_rsvd; cmd_valid && !cmd_sof && cidx_ff >= 6'h1E |-> cmd_data == 8'h00; endproperty
    a_cmd_rsvd: assert property (p_cmd_rsvd) else $error("command tail not zero");
    property p_rsp_rsvd; rsp_valid && !rsp_sof && ridx_ff >= 6'h1E |-> rsp_data == 8'h00; endproperty
    a_rsp_rsvd: assert property (p_rsp_rsvd) else $error("response tail not zero");
    property p_rsp_stat; rsp_valid && ridx_ff == 6'h19 && !rsp_data[6] |-> !rsp_data[7]; endproperty
    a_rsp_stat: assert property (p_rsp_stat) else $error("result set without done");

    c_done: cover property (rsp_valid && ridx_ff == 6'h19 && rsp_data[6]);
    c_abnormal: cover property (rsp_valid && ridx_ff == 6'h19 && rsp_data[7]);
    c_rsp_end: cover property ($fell(rsp_valid));
endmodule : net_frame_properties

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`include "net_frame_map.svh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin errors++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end

module tb_top;
    import net_frame_pkg::*;
    logic         mclk, arst_n, frame_start, reg_cmd_valid, reg_ack, reg_status, got_done, m2_status;
    logic         frame_done, code_err, reg_idle, reg_done, m_status, reg_req, bad_frame, d_busy, m_busy;
    logic         code_err2, bad_frame2;
    logic [127:0] io_in, io_out, m_io_out, d_io_in, m2_io_out, d2_io_in;
    logic [15:0]  d_axis;
    logic [13:0]  d_code;
    logic [31:0]  reg_rdata, m_rdata, d_wdata, m2_rdata, d2_wdata;
    logic [7:0]   rb [32];
    logic [5:0]   ri;
    int           errors, checks_done, nreq;
    logic [127:0] rows [2][2] = '{'{128'h7777_6666_5555_4444_3333_2222_1111_0000,
                                    128'h8000_4000_2000_1000_0800_0400_0200_0100},
                                  '{128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210,
                                    128'hFFFF_0000_A5A5_5A5A_0F0F_F0F0_1234_8765}};

    // ============================================================
    // Both variants, each pair of ends across its own link
    // ============================================================
    net_frame_if link ();
    net_frame_master #(.VARIANT(VAR_FIRST)) i_net_frame_master (.mclk(mclk), .arst_n(arst_n), .link(link),
        .frame_start(frame_start), .io_in_words(io_in), .reg_cmd_valid(reg_cmd_valid), .reg_axis(16'h0003),
        .reg_code(14'h1201), .reg_wdata(32'h0000_1388), .busy_ff(m_busy), .frame_done_ff(frame_done),
        .code_err_ff(code_err), .io_out_words_ff(m_io_out), .reg_idle_ff(reg_idle), .reg_done_ff(reg_done),
        .reg_status_ff(m_status), .reg_rdata_ff(m_rdata));
    net_frame_device #(.VARIANT(VAR_FIRST)) i_net_frame_device (.mclk(mclk), .arst_n(arst_n), .link(link),
        .io_in_words_ff(d_io_in), .io_update_ff(), .io_out_words(io_out), .reg_req_ff(reg_req),
        .reg_axis_ff(d_axis), .reg_code_ff(d_code), .reg_wdata_ff(d_wdata), .reg_ack(reg_ack),
        .reg_status(reg_status), .reg_rdata(reg_rdata), .reg_busy_ff(d_busy), .bad_frame_ff(bad_frame));
    net_frame_if link2 ();
    net_frame_master #(.VARIANT(VAR_SECOND)) i_net_frame_master_2 (.mclk(mclk), .arst_n(arst_n), .link(link2),
        .frame_start(frame_start), .io_in_words(io_in), .reg_cmd_valid(reg_cmd_valid), .reg_axis(16'h0003),
        .reg_code(14'h1201), .reg_wdata(32'h0000_1388), .busy_ff(), .frame_done_ff(), .code_err_ff(code_err2),
        .io_out_words_ff(m2_io_out), .reg_idle_ff(), .reg_done_ff(), .reg_status_ff(m2_status),
        .reg_rdata_ff(m2_rdata));
    net_frame_device #(.VARIANT(VAR_SECOND)) i_net_frame_device_2 (.mclk(mclk), .arst_n(arst_n), .link(link2),
        .io_in_words_ff(d2_io_in), .io_update_ff(), .io_out_words(io_out), .reg_req_ff(), .reg_axis_ff(),
        .reg_code_ff(), .reg_wdata_ff(d2_wdata), .reg_ack(reg_ack), .reg_status(reg_status),
        .reg_rdata(reg_rdata), .reg_busy_ff(), .bad_frame_ff(bad_frame2));
    net_frame_properties #(.CODE(`NF_CODE_FIRST)) i_net_frame_properties (.mclk(mclk), .arst_n(arst_n),
        .cmd_valid(link.cmd_valid), .cmd_sof(link.cmd_sof), .cmd_data(link.cmd_data),
        .rsp_valid(link.rsp_valid), .rsp_sof(link.rsp_sof), .rsp_data(link.rsp_data));

    // Clock, 5 ns period
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // Snoop pulses and response bytes
    always @(posedge mclk) begin
        if (reg_req === 1'b1) nreq++;
        if (reg_done === 1'b1) got_done <= 1'b1;
        if (link.rsp_valid === 1'b1) begin
            rb[link.rsp_sof ? 6'h00 : ri] <= link.rsp_data;
            ri <= link.rsp_sof ? 6'h01 : ri + 6'h01;
        end
    end

    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop

    // One exchange, bounded wait for done
    task automatic exchange(input logic [127:0] a, input logic [127:0] b);
        int n;
        @(posedge mclk);
        frame_start <= 1'b1;
        io_in       <= a;
        io_out      <= b;
        @(posedge mclk);
        frame_start <= 1'b0;
        for (n = 0; n < 200 && frame_done !== 1'b1; n++) begin
            @(posedge mclk);
        end
        if (n == 200) begin
            errors++;
            report_and_stop();
        end
        @(negedge mclk);
    endtask : exchange

    // ============================================================
    // Main sequence
    // ============================================================
    initial begin
        {arst_n, frame_start, reg_cmd_valid, reg_ack, reg_status, got_done} = 6'h00;
        {io_in, io_out, reg_rdata, ri} = '0;
        repeat (5) @(posedge mclk);
        arst_n <= 1'b1;
        @(negedge mclk);
        `CHK({reg_idle, reg_done}, 2'b10);
        foreach (rows[r]) begin
            exchange(rows[r][0], rows[r][1]);
            `CHK(d_io_in, rows[r][0]);
            `CHK(m_io_out, rows[r][1]);
            `CHK(rb[0], `NF_CODE_FIRST);
            `CHK({d2_io_in, m2_io_out}, {rows[r][0], rows[r][1]});
        end
        // Normal then abnormal result; second pass proves the clear
        for (int s = 0; s < 2; s++) begin
            @(posedge mclk);
            reg_cmd_valid <= 1'b1;
            @(posedge mclk);
            reg_cmd_valid <= 1'b0;
            repeat (2) exchange(rows[0][0], rows[0][1]);
            `CHK(nreq, s + 1);
            `CHK({d_axis, d_code, d_wdata}, {16'h0003, 14'h1201, 32'h0000_1388});
            `CHK(d_busy, 1'b1);
            @(posedge mclk);
            reg_ack    <= 1'b1;
            reg_status <= s[0];
            reg_rdata  <= 32'hCAFE_0000 + s;
            got_done   <= 1'b0;
            @(posedge mclk);
            reg_ack <= 1'b0;
            exchange(rows[1][0], rows[1][1]);
            `CHK({got_done, d_busy, m_busy}, 3'b100);
            `CHK(rb[25][7:6], {s[0], 1'b1});
            `CHK(m_status, s[0]);
            `CHK(m_rdata, 32'hCAFE_0000 + s);
            `CHK({d2_wdata, m2_status, m2_rdata}, {32'h0000_1388, s[0], 32'h00FE_0000 + s});
            `CHK({rb[25][5:0], rb[24]}, 14'h1201);
            `CHK({rb[23], rb[22]}, 16'h0003);
            exchange(rows[0][0], rows[0][1]);
            `CHK(reg_idle, 1'b1);
            `CHK(nreq, s + 1);
        end
        `CHK({code_err, bad_frame}, 2'b00);
        `CHK({code_err2, bad_frame2}, 2'b00);
        report_and_stop();
    end
endmodule : tb_top
